/* rtl/csd_top.sv */
// csd_top: programmable chip-select decoder, twelve channels
// assumes: bus inputs synchronous to clk; strobes active low;
// config ports written one cycle at a time by the integration logic
`timescale 1ns/100ps
`include "csd_params.svh"
module csd_top (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               sys_rst,
   // bus access
   input  wire logic [23:0]        acc_addr,
   input  wire logic [2:0]         function_code_lines,
   input  wire logic               acc_read,
   input  wire logic [1:0]         transfer_size_bits,
   input  wire logic               address_strobe_n,
   input  wire logic               data_strobe_n,
   input  wire logic               internal_hit,
   input  wire logic               slow_peripheral_clock,
   // channel settings write
   input  wire logic               cfg_wr,
   input  wire logic [3:0]         cfg_chan,
   input  wire csd_pkg::csd_chan_s cfg_word,
   // pin assignment and port data write
   input  wire logic               pa_wr,
   input  wire logic [23:0]        pa_data,
   input  wire logic               pd_wr,
   input  wire logic [6:0]         pd_data,
   input  wire logic [11:0]        strap_n,
   // pins and internal answers
   output logic [11:0]             pin_out_q,
   output logic [11:0]             alt_sel_q,
   output logic [1:0]              termination_ack_q,
   output logic                    autovector_request_q,
   output logic [23:0]             pin_assign_registers
);
   import csd_pkg::*;

   csd_chan_s   chan_q [`CSD_NUM_CH];
   logic [1:0]  pa_q [`CSD_NUM_CH];
   logic [6:0]  pd_q;
   logic        strap_pend_q;
   logic [11:0] hit;
   logic [11:0] sel_d;
   logic [11:0] sel_q;
   logic [11:0] pin_d;
   logic [11:0] disc_vec;
   logic        act;
   logic        act_q;
   logic        start;
   logic        slow_q;
   logic        sync_ok_q;
   logic        t_found;
   logic [3:0]  t_code;
   logic        t_16;
   logic        t_av;
   logic        won16_q;
   logic        wonav_q;
   logic        ctr_load;
   logic        expired;
   csd_term_e   state_q;

   csd_acc_if acc ();

   // channel settings; boot channel answers straight out of reset
   always_ff @(posedge clk) begin
      for (int i = 0; i < `CSD_NUM_CH; i++) begin
         if (sys_rst) begin
            chan_q[i] <= '0;
            if (i == `CSD_BOOT_CH) begin
               chan_q[i].base   <= `CSD_BOOT_BASE;
               chan_q[i].blk    <= `CSD_BLK_512K;
               chan_q[i].byte_f <= `CSD_BYTE_BOTH;
               chan_q[i].rw     <= `CSD_RW_BOTH;
               chan_q[i].space  <= `CSD_SP_EITHER;
               chan_q[i].term   <= `CSD_BOOT_TERM;
            end
         end else if (cfg_wr && cfg_chan == 4'(i)) begin
            chan_q[i] <= cfg_word;
         end
      end
   end

   // pin assignment; 00 writes to pins without a discrete use are dropped
   always_ff @(posedge clk) begin
      for (int i = 0; i < `CSD_NUM_CH; i++) begin
         if (sys_rst) begin
            pa_q[i] <= `CSD_PA_RST;
         end else if (strap_pend_q && !strap_n[i]) begin
            pa_q[i] <= `CSD_PA_ALT;
         end else if (pa_wr) begin
            if (pa_data[2*i +: 2] != `CSD_PA_DISC ||
                (i >= 3 && i != `CSD_BOOT_CH))
               pa_q[i] <= pa_data[2*i +: 2];
         end
      end
   end

   // straps are sampled on the first edge after reset falls
   always_ff @(posedge clk) begin
      strap_pend_q <= sys_rst;
   end

   // discrete output data
   always_ff @(posedge clk) begin
      if (sys_rst)
         pd_q <= `CSD_PD_RST;
      else if (pd_wr)
         pd_q <= pd_data;
   end

   // read-back of the assignment fields
   always_ff @(posedge clk) begin
      for (int i = 0; i < `CSD_NUM_CH; i++) begin
         pin_assign_registers[2*i +: 2] <= sys_rst ? `CSD_PA_RST : pa_q[i];
         alt_sel_q[i] <= !sys_rst && pa_q[i] == `CSD_PA_ALT;
      end
   end

   // one copy of the access fans out to all matchers
   assign acc.addr = acc_addr;
   assign acc.fc   = function_code_lines;
   assign acc.read = acc_read;
   assign acc.size = transfer_size_bits;

   // every channel compares on its own; overlaps are not arbitrated
   for (genvar g = 0; g < `CSD_NUM_CH; g++) begin : g_ch
      csd_chan_match u_match (
         .cfg    (chan_q[g]),
         .port16 (pa_q[g] == `CSD_PA_CS16),
         .acc    (acc.dst),
         .hit    (hit[g])
      );
   end

   // an internal target suppresses the whole external cycle
   assign act   = !address_strobe_n && !internal_hit;
   assign start = act && !act_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         act_q  <= 1'b0;
         slow_q <= 1'b0;
      end else begin
         act_q  <= act;
         slow_q <= slow_peripheral_clock;
      end
   end

   // slow-clock mode waits for a rising slow edge inside the cycle
   always_ff @(posedge clk) begin
      if (sys_rst)
         sync_ok_q <= 1'b0;
      else
         sync_ok_q <= act && (sync_ok_q ||
                      (slow_peripheral_clock && !slow_q));
   end

   // select timing per channel
   always_comb begin
      for (int i = 0; i < `CSD_NUM_CH; i++) begin
         if (chan_q[i].mode)
            sel_d[i] = hit[i] && act && sync_ok_q;
         else if (chan_q[i].strobe_choice_bit)
            sel_d[i] = hit[i] && act && !data_strobe_n;
         else
            sel_d[i] = hit[i] && act;
      end
   end

   // pins 3..9 carry port bits, pin 10 the slow clock, others idle high
   assign disc_vec = {1'b1, slow_peripheral_clock, pd_q, 3'h7};

   always_comb begin
      for (int i = 0; i < `CSD_NUM_CH; i++) begin
         case (pa_q[i])
            `CSD_PA_DISC: pin_d[i] = disc_vec[i];
            `CSD_PA_ALT:  pin_d[i] = 1'b1;
            default:      pin_d[i] = !sel_d[i];
         endcase
      end
   end

   // pins are registered so the pads see clean levels
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_out_q <= 12'hFFF;
         sel_q     <= 12'h000;
      end else begin
         pin_out_q <= pin_d;
         sel_q     <= sel_d;
      end
   end

   // lowest matching async channel owns the shared counter; a hazard
   // only if overlapping channels disagree on wait count, port width or autovector
   always_comb begin
      t_found = 1'b0;
      t_code  = 4'h0;
      t_16    = 1'b0;
      t_av    = 1'b0;
      for (int i = `CSD_NUM_CH - 1; i >= 0; i--) begin
         if (hit[i] && !chan_q[i].mode &&
             chan_q[i].term != `CSD_TERM_EXT) begin
            t_found = 1'b1;
            t_code  = chan_q[i].term;
            t_16    = pa_q[i][0];
            t_av    = chan_q[i].autovector_request && chan_q[i].space == `CSD_SP_CPU;
         end
      end
   end

   assign ctr_load = state_q == CSD_IDLE && start && t_found &&
                     t_code != `CSD_TERM_FAST;

   csd_wait_ctr u_wait (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .load      (ctr_load),
      .count     (4'(t_code * `CSD_WAIT_CYC)),
      .abort     (!act),
      .expired_q (expired)
   );

   // termination: acknowledge held until the strobe goes away
   always_ff @(posedge clk) begin
      if (sys_rst || !act) begin
         state_q              <= CSD_IDLE;
         termination_ack_q    <= 2'h0;
         autovector_request_q <= 1'b0;
         won16_q              <= 1'b0;
         wonav_q              <= 1'b0;
      end else begin
         case (state_q)
            CSD_IDLE: if (start && t_found) begin
               won16_q <= t_16;
               wonav_q <= t_av;
               if (t_code == `CSD_TERM_FAST) begin
                  state_q              <= CSD_ACK;
                  termination_ack_q    <= t_16 ? 2'h2 : 2'h1;
                  autovector_request_q <= t_av;
               end else begin
                  state_q <= CSD_COUNT;
               end
            end
            CSD_COUNT: if (expired) begin
               state_q              <= CSD_ACK;
               termination_ack_q    <= won16_q ? 2'h2 : 2'h1;
               autovector_request_q <= wonav_q;
            end
            CSD_ACK: state_q <= CSD_ACK;
            default: state_q <= CSD_IDLE;
         endcase
      end
   end

   AST_BOOT_RESET: assert property (@(posedge clk)
      $past(sys_rst) |-> chan_q[`CSD_BOOT_CH].blk == `CSD_BLK_512K &&
         chan_q[`CSD_BOOT_CH].base == `CSD_BOOT_BASE)
      else $error("boot channel not at its reset region");
   AST_GEN_DISABLED: assert property (@(posedge clk)
      $past(sys_rst) |-> chan_q[0].byte_f == `CSD_BYTE_OFF)
      else $error("general channel enabled out of reset");
   AST_DISABLED_QUIET: assert property (@(posedge clk)
      disable iff (sys_rst)
      chan_q[0].byte_f == `CSD_BYTE_OFF |-> !hit[0] ##1 pin_out_q[0] ||
         pa_q[0] == `CSD_PA_ALT)
      else $error("disabled channel responded");
   AST_INTERNAL_WINS: assert property (@(posedge clk)
      disable iff (sys_rst) internal_hit |=> sel_q == 12'h000)
      else $error("select asserted on an internal access");
   AST_NO_DISC_ARB: assert property (@(posedge clk)
      disable iff (sys_rst)
      pa_q[`CSD_BOOT_CH] != `CSD_PA_DISC && pa_q[0] != `CSD_PA_DISC &&
      pa_q[1] != `CSD_PA_DISC && pa_q[2] != `CSD_PA_DISC)
      else $error("pin without discrete use holds 00");
   AST_STRAP_ALT: assert property (@(posedge clk)
      strap_pend_q && !sys_rst && !strap_n[0] |=> pa_q[0] == `CSD_PA_ALT)
      else $error("strap did not select alternate function");
   AST_DISC_PIN: assert property (@(posedge clk)
      disable iff (sys_rst)
      pa_q[3] == `CSD_PA_DISC |=> pin_out_q[3] == $past(pd_q[0]))
      else $error("discrete pin does not follow port bit");
   AST_SYNC_SELECT: assert property (@(posedge clk)
      disable iff (sys_rst)
      sel_d[5] && chan_q[5].mode |-> sync_ok_q && act)
      else $error("slow mode select before slow clock edge");
   AST_FAST_ACK: assert property (@(posedge clk)
      disable iff (sys_rst)
      state_q == CSD_IDLE && start && t_found &&
      t_code == `CSD_TERM_FAST |=> termination_ack_q != 2'h0)
      else $error("fast termination not acknowledged next cycle");
   AST_ZERO_WAIT: assert property (@(posedge clk)
      disable iff (sys_rst)
      (state_q == CSD_IDLE && start && t_found && t_code == 4'h0)
      ##1 act[*3] |-> termination_ack_q != 2'h0)
      else $error("zero wait cycle not acknowledged after three cycles");
   AST_EXT_NO_ACK: assert property (@(posedge clk)
      disable iff (sys_rst)
      state_q == CSD_IDLE && start && !t_found |=>
      termination_ack_q == 2'h0)
      else $error("external termination acknowledged internally");
endmodule : csd_top

/* rtl/csd_params.svh */
// csd_params.svh: constants of the chip-select decoder
// assumes: included by bare name from the rtl files, after the package
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH

`define CSD_NUM_CH     12
`define CSD_BOOT_CH    11
`define CSD_SLOW_PIN   10
// timing: clock period and one wait state, in picoseconds
`define CSD_CLK_PS     5000
`define CSD_WAIT_PS    5000
`define CSD_WAIT_CYC   ((`CSD_WAIT_PS + `CSD_CLK_PS - 1) / `CSD_CLK_PS)
// field encodings
`define CSD_BLK_512K   3'h6
`define CSD_BYTE_OFF   2'h0
`define CSD_BYTE_LO    2'h1
`define CSD_BYTE_HI    2'h2
`define CSD_BYTE_BOTH  2'h3
`define CSD_RW_RD      2'h1
`define CSD_RW_WR      2'h2
`define CSD_RW_BOTH    2'h3
`define CSD_SP_CPU     2'h0
`define CSD_SP_USER    2'h1
`define CSD_SP_SUPV    2'h2
`define CSD_SP_EITHER  2'h3
`define CSD_TERM_FAST  4'hE
`define CSD_TERM_EXT   4'hF
`define CSD_PA_DISC    2'h0
`define CSD_PA_ALT     2'h1
`define CSD_PA_CS8     2'h2
`define CSD_PA_CS16    2'h3
`define CSD_IPL_ALL    3'h0
`define CSD_FC_CPU     3'h7
`define CSD_IACK_TYPE  4'hF
`define CSD_SIZE_BYTE  2'h1
// reset values
`define CSD_BOOT_BASE  13'h0000
`define CSD_BOOT_TERM  4'hD
`define CSD_PA_RST     2'h3
`define CSD_PD_RST     7'h00
`endif

/* rtl/csd_pkg.sv */
// csd_pkg: types shared by the chip-select decoder files
// assumes: compiled before every other rtl file
package csd_pkg;
   // one channel's base and option settings
   typedef struct packed {
      logic [12:0] base;    // compares against addr[23:11]
      logic [2:0]  blk;
      logic        mode;    // 1: slow clock synchronised
      logic [1:0]  byte_f;
      logic [1:0]  rw;
      logic        strobe_choice_bit;
      logic [3:0]  term;
      logic [1:0]  space;
      logic [2:0]  irq_level_field;
      logic        autovector_request;
   } csd_chan_s;
   typedef enum logic [1:0] {CSD_IDLE, CSD_COUNT, CSD_ACK} csd_term_e;
endpackage : csd_pkg

/* rtl/csd_acc_if.sv */
// csd_acc_if: one bus access as seen by every channel matcher
// assumes: driven by the top, read by the matchers
`timescale 1ns/100ps
interface csd_acc_if;
   logic [23:0] addr;
   logic [2:0]  fc;
   logic        read;
   logic [1:0]  size;
   modport src (output addr, output fc, output read, output size);
   modport dst (input addr, input fc, input read, input size);
endinterface : csd_acc_if

/* rtl/csd_chan_match.sv */
// csd_chan_match: address and control compare of one channel
// assumes: access fields stable while address strobe is low
`timescale 1ns/100ps
`include "csd_params.svh"
module csd_chan_match (
   // channel settings
   input  wire csd_pkg::csd_chan_s cfg,
   input  wire logic               port16,
   // access
   csd_acc_if.dst                  acc,
   // result
   output logic                    hit
);
   import csd_pkg::*;
   logic [12:0] mask;
   logic        iack;
   logic        a_ok;
   logic        s_ok;
   logic        w_ok;
   logic        b_ok;
   logic        l_ok;

   // upper lines only; base bits below the block size never take part
   always_comb begin
      case (cfg.blk)
         3'h0:    mask = 13'h1FFF;
         3'h1:    mask = 13'h1FFC;
         3'h2:    mask = 13'h1FF8;
         3'h3:    mask = 13'h1FE0;
         3'h4:    mask = 13'h1FC0;
         3'h5:    mask = 13'h1F80;
         3'h6:    mask = 13'h1F00;
         default: mask = 13'h1E00;
      endcase
   end

   assign iack = (acc.fc == `CSD_FC_CPU) &&
                 (acc.addr[19:16] == `CSD_IACK_TYPE);
   assign a_ok = ((acc.addr[23:11] ^ cfg.base) & mask) == 13'h0000;
   // space: cpu space only for 00; 01 and 10 use fc[2] for user or supervisor, 11 takes any but cpu
   always_comb begin
      case (cfg.space)
         `CSD_SP_CPU:  s_ok = acc.fc == `CSD_FC_CPU;
         `CSD_SP_USER: s_ok = !acc.fc[2];
         `CSD_SP_SUPV: s_ok = acc.fc[2] && acc.fc != `CSD_FC_CPU;
         default:      s_ok = acc.fc != `CSD_FC_CPU;
      endcase
   end
   assign w_ok = acc.read ? cfg.rw[0] : cfg.rw[1];
   // byte lanes only matter on a 16-bit port
   always_comb begin
      case (cfg.byte_f)
         `CSD_BYTE_OFF: b_ok = 1'b0;
         `CSD_BYTE_HI:  b_ok = !port16 || !acc.addr[0];
         `CSD_BYTE_LO:  b_ok = !port16 || acc.addr[0] ||
                               acc.size != `CSD_SIZE_BYTE;
         default:       b_ok = 1'b1;
      endcase
   end
   assign l_ok = !iack || cfg.irq_level_field == `CSD_IPL_ALL ||
                 cfg.irq_level_field == acc.addr[3:1];
   assign hit = a_ok && s_ok && w_ok && b_ok && l_ok;
endmodule : csd_chan_match

/* rtl/csd_wait_ctr.sv */
// csd_wait_ctr: the one wait-state counter shared by all channels
// assumes: load is a single-cycle pulse; abort ends a count early
`timescale 1ns/100ps
`include "csd_params.svh"
module csd_wait_ctr (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // control
   input  wire logic       load,
   input  wire logic [3:0] count,
   input  wire logic       abort,
   // result
   output logic            expired_q
);
   import csd_pkg::*;
   logic [3:0] cnt_q;
   logic       busy_q;

   // one decrement per clock, so one wait state is one cycle
   always_ff @(posedge clk) begin
      if (sys_rst || abort) begin
         cnt_q     <= 4'h0;
         busy_q    <= 1'b0;
         expired_q <= 1'b0;
      end else if (load) begin
         cnt_q     <= count;
         busy_q    <= 1'b1;
         expired_q <= 1'b0;
      end else begin
         expired_q <= busy_q && cnt_q == 4'h0;
         busy_q    <= busy_q && cnt_q != 4'h0;
         cnt_q     <= (busy_q && cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q;
      end
   end

   AST_WAIT_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      (load && count == 4'h0) ##1 !abort |=> expired_q)
      else $error("zero wait count did not expire after two cycles");
   AST_WAIT_THREE: assert property (@(posedge clk) disable iff (sys_rst)
      (load && count == 4'h3) |=> !expired_q[*4])
      else $error("three wait count expired early");
endmodule : csd_wait_ctr

/* testbench/csd_ext_dev.sv */
// csd_ext_dev: external devices hung on the select pins
// assumes: select pins active low, sampled on the rising clk edge
`timescale 1ns/100ps
module csd_ext_dev (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // select pins
   input  wire logic [11:0] sel_n,
   // record of devices ever selected
   output logic      [11:0] seen_q
);
   // sticky per device, so a stray select is never missed
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         seen_q <= 12'h000;
      end else begin
         seen_q <= seen_q | ~sel_n;
      end
   end
endmodule : csd_ext_dev

/* testbench/csd_top_tb_top.sv */
// csd_top_tb_top: directed tests of the chip-select decoder
// assumes: csd_pkg and the rtl files are compiled first
`timescale 1ns/100ps
module csd_top_tb_top;
   import csd_pkg::*;
   logic        clk, sys_rst, as_n, rd, ih, cfg_wr, pa_wr, pd_wr, autovector_request;
   logic        ds_n, sclk, avs;
   logic [23:0] addr, pa_data, pa_rb;
   logic [2:0]  fc;
   logic [1:0]  sz, ack, av;
   logic [3:0]  cfg_chan;
   logic [6:0]  pd_data;
   logic [11:0] strap_n, pins, alt, seen, pv;
   csd_chan_s   cfg_word;
   int          bad_count = 0;
   int          cmp_count = 0;

   csd_top DUT (.clk(clk), .sys_rst(sys_rst), .acc_addr(addr),
      .function_code_lines(fc), .acc_read(rd), .transfer_size_bits(sz),
      .address_strobe_n(as_n), .data_strobe_n(ds_n), .internal_hit(ih),
      .slow_peripheral_clock(sclk), .cfg_wr(cfg_wr), .cfg_chan(cfg_chan),
      .cfg_word(cfg_word), .pa_wr(pa_wr), .pa_data(pa_data),
      .pd_wr(pd_wr), .pd_data(pd_data), .strap_n(strap_n),
      .pin_out_q(pins), .alt_sel_q(alt), .termination_ack_q(ack),
      .autovector_request_q(autovector_request), .pin_assign_registers(pa_rb));

   csd_ext_dev u_dev (.clk(clk), .sys_rst(sys_rst), .sel_n(pins),
      .seen_q(seen));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // free-running slow bus clock, eight system clocks a period
   initial begin
      sclk = 1'b0;
      forever begin
         repeat (4) @(negedge clk);
         sclk = ~sclk;
      end
   end

   task automatic chk(input string nm, input logic [23:0] s, e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   // one strobe period of k rising edges; strobe then high 3 cycles
   task automatic acc(input logic [23:0] a, input logic r, i,
                      input logic [1:0] s, input int k);
      addr = a;
      rd = r;
      ih = i;
      sz = s;
      as_n = 1'b0;
      ds_n = 1'b0;
      repeat (k) @(negedge clk);
      pv = pins;
      av = ack;
      avs = autovector_request;
      as_n = 1'b1;
      ds_n = 1'b1;
      repeat (3) @(negedge clk);
   endtask : acc

   // read-only, either space, async strobe timing
   task automatic set_ch(input logic [3:0] ch, input logic [12:0] b,
                         input logic [2:0] bk, input logic [1:0] by);
      cfg_chan = ch;
      cfg_word = '0;
      cfg_word.base = b;
      cfg_word.blk = bk;
      cfg_word.byte_f = by;
      cfg_word.rw = 2'h1;
      cfg_word.term = 4'hE;
      cfg_word.space = 2'h3;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask : set_ch

   // rewrite option fields of the channel last set; the leading wait
   // keeps cfg_wr low for a cycle after a preceding set_ch
   task automatic opt(input logic [1:0] sp, input logic [2:0] lv,
                      input logic ve, input logic [3:0] tm,
                      input logic md, input logic sb);
      cfg_word.space = sp;
      cfg_word.irq_level_field = lv;
      cfg_word.autovector_request = ve;
      cfg_word.term = tm;
      cfg_word.mode = md;
      cfg_word.strobe_choice_bit = sb;
      @(negedge clk);
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask : opt

   task automatic wr_pin(input logic [23:0] p, input logic [6:0] d);
      pa_data = p;
      pd_data = d;
      pa_wr = 1'b1;
      pd_wr = 1'b1;
      @(negedge clk);
      pa_wr = 1'b0;
      pd_wr = 1'b0;
      @(negedge clk);
   endtask : wr_pin

   // guard against a hang: more than ten times the expected run
   initial begin
      #20000;
      bad_count++;
      tally_and_finish();
   end

   initial begin
      {sys_rst, as_n, ds_n, rd} = 4'hF;
      {ih, cfg_wr, pa_wr, pd_wr} = 4'h0;
      {addr, pa_data, pd_data, cfg_chan} = '0;
      {fc, sz} = 5'h0A;
      cfg_word = '0;
      strap_n = 12'hFFE;
      repeat (12) @(negedge clk);
      chk("reset pins", pins, 24'hFFF);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk);
      chk("strap alt", alt, 24'h001);
      chk("assign", pa_rb, 24'hFFFFFD);
      $display("test reset done");
      acc(24'h000100, 1'b1, 1'b0, 2'h2, 15);
      chk("boot sel", pv, 24'h7FF);
      chk("ack early", av, 24'h0);
      acc(24'h000100, 1'b1, 1'b0, 2'h2, 16);
      chk("ack 13 waits", av, 24'h2);
      acc(24'h080000, 1'b1, 1'b0, 2'h2, 4);
      chk("boot limit", pv, 24'hFFF);
      $display("test boot done");
      // base 023800, 64K: low base bits are ignored
      set_ch(4'h3, 13'h0047, 3'h3, 2'h3);
      acc(24'h02FFFE, 1'b1, 1'b0, 2'h2, 2);
      chk("overlap", pv, 24'h7F7);
      chk("fast ack", av, 24'h2);
      acc(24'h030000, 1'b1, 1'b0, 2'h2, 2);
      chk("outside", pv, 24'h7FF);
      acc(24'h020000, 1'b0, 1'b0, 2'h2, 2);
      chk("write", pv, 24'h7FF);
      acc(24'h020000, 1'b1, 1'b1, 2'h2, 2);
      chk("internal", {pv, 10'h0, av}, {12'hFFF, 12'h0});
      $display("test match done");
      set_ch(4'h3, 13'h0047, 3'h3, 2'h2);
      acc(24'h020001, 1'b1, 1'b0, 2'h1, 2);
      chk("lane odd", pv, 24'h7FF);
      acc(24'h020000, 1'b1, 1'b0, 2'h1, 2);
      chk("lane even", pv, 24'h7F7);
      wr_pin(24'hFFFFBC, 7'h00);
      chk("refuse 00", pa_rb, 24'hFFFFBD);
      acc(24'h020001, 1'b1, 1'b0, 2'h1, 2);
      chk("8-bit sel", pv, 24'h7F7);
      chk("8-bit ack", av, 24'h1);
      $display("test port done");
      wr_pin(24'hFFFF3C, 7'h01);
      chk("disc high", pins, 24'hFFF);
      wr_pin(24'hFFFF3C, 7'h00);
      chk("disc low", pins, 24'hFF7);
      acc(24'h020000, 1'b1, 1'b0, 2'h2, 2);
      chk("disc sel", pv, 24'h7F7);
      chk("disc ack", |av, 24'h1);
      set_ch(4'h3, 13'h0047, 3'h3, 2'h0);
      acc(24'h020000, 1'b1, 1'b0, 2'h2, 2);
      chk("disabled", {pv, 10'h0, av}, {12'h7F7, 12'h0});
      chk("never sel", seen, 24'h808);
      $display("test disc done");
      // interrupt acknowledge at level 5 with autovector on channel 4
      set_ch(4'h4, 13'h1FFF, 3'h0, 2'h3);
      opt(2'h0, 3'h5, 1'b1, 4'hE, 1'b0, 1'b0);
      fc = 3'h7;
      acc(24'hFFFFFB, 1'b1, 1'b0, 2'h2, 2);
      chk("iack sel", pv, 24'hFE7);
      chk("iack ack", av, 24'h2);
      chk("autovector", avs, 24'h1);
      acc(24'hFFFFF9, 1'b1, 1'b0, 2'h2, 2);
      chk("iack level", {pv, 10'h0, av}, {12'hFF7, 12'h0});
      fc = 3'h2;
      $display("test iack done");
      // code n acknowledges n+2 edges after the first strobe edge
      opt(2'h3, 3'h0, 1'b0, 4'h3, 1'b0, 1'b0);
      acc(24'hFFF800, 1'b1, 1'b0, 2'h2, 5);
      chk("3 waits early", av, 24'h0);
      acc(24'hFFF800, 1'b1, 1'b0, 2'h2, 6);
      chk("3 waits", av, 24'h2);
      opt(2'h3, 3'h0, 1'b0, 4'h0, 1'b0, 1'b0);
      acc(24'hFFF800, 1'b1, 1'b0, 2'h2, 2);
      chk("0 waits early", av, 24'h0);
      acc(24'hFFF800, 1'b1, 1'b0, 2'h2, 4);
      chk("0 waits", av, 24'h2);
      opt(2'h3, 3'h0, 1'b0, 4'hF, 1'b0, 1'b0);
      acc(24'hFFF800, 1'b1, 1'b0, 2'h2, 6);
      chk("external", {pv, 10'h0, av}, {12'hFE7, 12'h0});
      $display("test wait done");
      // slow-clock channel 5 waits for a rising slow edge, never acks
      set_ch(4'h5, 13'h0200, 3'h0, 2'h3);
      opt(2'h3, 3'h0, 1'b0, 4'hE, 1'b1, 1'b0);
      acc(24'h100000, 1'b1, 1'b0, 2'h2, 1);
      chk("slow early", pv, 24'hFF7);
      acc(24'h100000, 1'b1, 1'b0, 2'h2, 10);
      chk("slow sel", pv, 24'hFD7);
      chk("slow no ack", av, 24'h0);
      // channel 6 on the data strobe: select waits for it
      set_ch(4'h6, 13'h0300, 3'h0, 2'h3);
      opt(2'h3, 3'h0, 1'b0, 4'hE, 1'b0, 1'b1);
      addr = 24'h180000;
      as_n = 1'b0;
      repeat (2) @(negedge clk);
      chk("strobe wait", pins, 24'hFF7);
      ds_n = 1'b0;
      repeat (2) @(negedge clk);
      chk("strobe sel", pins, 24'hFB7);
      as_n = 1'b1;
      ds_n = 1'b1;
      repeat (3) @(negedge clk);
      $display("test timing done");
      tally_and_finish();
   end
endmodule : csd_top_tb_top
